// ---- dv/sample_queue_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sample_queue_regs.vh"
// ==========================================================
// port-level checker, mirrors only the mode field
module sample_queue_chk (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata_r,
  input wire logic [6:0] next_addr_r,
  input wire logic       ev_single_knock,
  input wire logic       ev_double_knock,
  input wire logic       ev_freefall,
  input wire logic       ev_wakeup,
  input wire logic       ev_orientation,
  input wire logic       queue_full_flag_r,
  input wire logic       post_trigger_r
);
  logic [2:0] mode_r;   // last mode written
  wire        ev_any  = ev_single_knock | ev_double_knock | ev_freefall | ev_wakeup | ev_orientation;
  wire        mode_wr = wr_stb && addr == `ADDR_QUEUE_CONTROL_D;
  // mode mirror; routing is not mirrored, so trigger causes stay loose
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      mode_r <= `MODE_BYPASS;
    else if (mode_wr)
      mode_r <= wdata[2:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_rdata_quiet: assert property (!$past(rd_stb) |-> rdata_r == 8'h00)
    else $error("read data outside read slot");
  a_burst_wrap: assert property (rd_stb && addr == `ADDR_OUT_BYTE_5 |=> next_addr_r == `ADDR_OUT_TAG)
    else $error("burst address did not wrap");
  a_burst_step: assert property (rd_stb && addr >= `ADDR_OUT_TAG && addr < `ADDR_OUT_BYTE_5
    |=> next_addr_r == $past(addr) + 7'h01)
    else $error("burst address did not step");
  a_bypass_clear: assert property (mode_wr && wdata[2:0] == `MODE_BYPASS
    |-> ##2 !post_trigger_r && !queue_full_flag_r)
    else $error("bypass left flags set");
  a_trig_holds: assert property (post_trigger_r && !mode_wr && mode_r != `MODE_BYPASS |=> post_trigger_r)
    else $error("trigger phase dropped");
  a_trig_cause: assert property ($rose(post_trigger_r) |-> $past(ev_any) || $past(ev_any, 2))
    else $error("trigger without event");
  a_bypass_idle: assert property (mode_r == `MODE_BYPASS && $past(mode_r) == `MODE_BYPASS
    |-> !post_trigger_r)
    else $error("trigger phase in bypass");
  a_wtm_masked: assert property (mode_r == `MODE_WTM_TO_FULL && !post_trigger_r |-> !queue_full_flag_r)
    else $error("full flag not masked");
  a_pretrig_empty: assert property ((mode_r == `MODE_BYPASS_TO_CONT || mode_r == `MODE_BYPASS_TO_STOP)
    && !post_trigger_r |-> !queue_full_flag_r)
    else $error("full flag before trigger");
endmodule // sample_queue_chk
bind triggered_sample_queue_modes sample_queue_chk chk_inst (.clk, .nrst, .addr, .wdata, .wr_stb, .rd_stb,
  .rdata_r, .next_addr_r, .ev_single_knock, .ev_double_knock, .ev_freefall, .ev_wakeup, .ev_orientation,
  .queue_full_flag_r, .post_trigger_r);
`default_nettype wire

// ---- dv/sample_source.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// sensor side: one data-ready pulse per word, 80 ns period
module sample_source (
  output var logic        sample_clk,
  output var logic [55:0] sample_word
);
  // link clock stands still low between frames
  initial
  begin
    sample_clk  = 1'b0;
    sample_word = 56'h0;
  end
  // word stable for a whole period, then inverted so stale data never looks valid
  task automatic send(input logic [55:0] w);
    #3;
    sample_word = w;
    sample_clk  = 1'b1;
    #40;
    sample_clk  = 1'b0;
    #40;
    sample_word = ~w;
  endtask
endmodule // sample_source
`default_nettype wire

// ---- dv/triggered_sample_queue_modes_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sample_queue_regs.vh"
// ==========================================================
// bench: reference queue model against the design
module triggered_sample_queue_modes_tb;
  logic        clk, nrst, wr_stb, rd_stb, trig, halt, ovr;
  logic [6:0]  addr;
  logic [7:0]  wdata;
  logic [4:0]  ev;           // detector levels, routing-bit order
  logic [2:0]  mode;         // reference mode field
  wire  [7:0]  rdata_r;
  wire  [6:0]  next_addr_r;
  wire         sample_clk, queue_full_flag_r, post_trigger_r;
  wire  [55:0] sample_word;
  int          miscompares, n_compared, thr;
  logic [55:0] q[$];         // reference contents, oldest first
  triggered_sample_queue_modes triggered_sample_queue_modes_inst (.clk, .nrst, .addr, .wdata, .wr_stb, .rd_stb,
    .rdata_r, .next_addr_r, .sample_clk, .sample_word, .ev_single_knock(ev[0]), .ev_double_knock(ev[1]),
    .ev_freefall(ev[2]), .ev_wakeup(ev[3]), .ev_orientation(ev[4]), .queue_full_flag_r, .post_trigger_r);
  sample_source sample_source_inst (.sample_clk, .sample_word);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // register bus cycles
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr   <= a;
    wdata  <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 check(rdata_r & m, e & m);
  endtask
  task automatic setmode(input logic [2:0] m);
    wr(`ADDR_QUEUE_CONTROL_D, {5'h00, m});
    mode = m;
    trig = 1'b0;
    if (m == `MODE_BYPASS)
    begin
      q.delete();
      ovr = 1'b0;
    end
  endtask
  // ==========================================================
  // reference model of storage
  function automatic int cap();
    return ((mode == `MODE_WTM_TO_FULL) ? !trig : halt) ? thr : 256;
  endfunction
  task automatic push;
    logic [55:0] w;
    w = {8'($urandom_range(0, 254)), 16'($urandom), 32'($urandom)};
    @(posedge clk);
    sample_source_inst.send(w);
    repeat (6) @(posedge clk);
    if (mode == `MODE_BYPASS || (mode != `MODE_WTM_TO_FULL && !trig))
      return;
    if (q.size() >= cap() && (mode == `MODE_BYPASS_TO_CONT || !trig))
    begin
      void'(q.pop_front());
      ovr = 1'b1;
    end
    if (q.size() < cap())
      q.push_back(w);
  endtask
  task automatic status;
    logic       full;
    logic       wm;
    logic [8:0] sz;
    sz   = 9'(q.size());
    wm   = q.size() >= thr;
    full = mode != `MODE_BYPASS && !(mode == `MODE_WTM_TO_FULL && !trig) && q.size() + 1 >= cap();
    rd(`ADDR_QUEUE_STATE_A, sz[7:0], 8'hFF);
    rd(`ADDR_QUEUE_STATE_B, {wm, ovr, full, 4'h0, sz[8]}, 8'hE1);
    ovr = 1'b0;
    check(queue_full_flag_r, full);
  endtask
  task automatic rdword;
    logic [55:0] w;
    w = q.size() ? q.pop_front() : {`EMPTY_TAG, 48'h0};
    rd(`ADDR_OUT_TAG, w[55:48], 8'hFF);
    for (int k = 0; k < 6; k++)
      rd(7'(`ADDR_OUT_BYTE_0 + k), w[8*k +: 8], 8'hFF);
    check(next_addr_r, `ADDR_OUT_TAG);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev <= 5'(1 << i);
    repeat (3) @(posedge clk);
    ev <= 5'h00;
    repeat (3) @(posedge clk);
  endtask
  // ==========================================================
  // hang guard
  initial
  begin
    repeat (100000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(76));
    {wr_stb, rd_stb, addr, wdata, ev, mode, trig, halt, ovr} = '0;
    {miscompares, n_compared, thr} = '0;
    nrst = 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    status();
    rd(7'h30, 8'h00, 8'hFF);
    push();
    status();
    // each source through one triggered mode in turn; unrouted ones are ignored
    for (int i = 0; i < 5; i++)
    begin
      setmode(`MODE_BYPASS);
      wr(`ADDR_IRQ_B_ROUTING, 8'(1 << i));
      setmode(i % 3 == 0 ? `MODE_BYPASS_TO_CONT : i % 3 == 1 ? `MODE_BYPASS_TO_STOP : `MODE_WTM_TO_FULL);
      pulse((i + 1) % 5);
      check(post_trigger_r, 1'b0);
      pulse(i);
      check(post_trigger_r, 1'b1);
    end
    // halt at two words: overwrite versus stop, then drain past empty
    wr(`ADDR_QUEUE_CONTROL_A, 8'h02);
    wr(`ADDR_QUEUE_CONTROL_B, 8'h01);
    {thr, halt} = {32'd2, 1'b1};
    for (int j = 0; j < 2; j++)
    begin
      setmode(`MODE_BYPASS);
      setmode(j ? `MODE_BYPASS_TO_STOP : `MODE_BYPASS_TO_CONT);
      push();
      status();
      pulse(4);
      trig = 1'b1;
      repeat (3) begin push(); status(); end
      repeat (3) rdword();
      status();
    end
    // threshold three before trigger, whole queue after
    wr(`ADDR_QUEUE_CONTROL_B, 8'h00);
    wr(`ADDR_QUEUE_CONTROL_A, 8'h03);
    {thr, halt} = {32'd3, 1'b0};
    setmode(`MODE_BYPASS);
    setmode(`MODE_WTM_TO_FULL);
    repeat (5) push();
    status();
    rdword();
    pulse(4);
    trig = 1'b1;
    repeat (256) push();
    status();
    rdword();
    status();
    report_and_stop();
  end
endmodule // triggered_sample_queue_modes_tb
`default_nettype wire

// ---- verilog/edge_sync.v ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two-flop synchroniser with rising-edge pulse
module edge_sync (
  input  wire clk,
  input  wire nrst,
  input  wire async_in,
  output reg  rise_r
);
  reg meta_r;   // first stage, read only by stage two
  reg sync_r;   // second stage
  reg prev_r;   // delayed copy for edge finding

  // ==========================================================
  // synchroniser and edge detector
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      rise_r <= 1'b0;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      rise_r <= sync_r & ~prev_r;
    end
  end
endmodule // edge_sync
`default_nettype wire

// ---- verilog/sample_queue_regs.vh ----
`ifndef SAMPLE_QUEUE_REGS_VH
`define SAMPLE_QUEUE_REGS_VH
// ==========================================================
// register offsets (7-bit register address)
`define ADDR_QUEUE_CONTROL_A   7'h07
`define ADDR_QUEUE_CONTROL_B   7'h08
`define ADDR_QUEUE_CONTROL_D   7'h0A
`define ADDR_QUEUE_STATE_A     7'h1B
`define ADDR_QUEUE_STATE_B     7'h1C
`define ADDR_IRQ_B_ROUTING     7'h5E
`define ADDR_OUT_TAG           7'h78
`define ADDR_OUT_BYTE_0        7'h79
`define ADDR_OUT_BYTE_5        7'h7E
// ==========================================================
// field positions
`define BIT_HALT_AT_THRESHOLD  0
`define BIT_STATE_B_COUNT_MSB  0
`define BIT_STATE_B_OVERRUN    6
`define BIT_STATE_B_FULL       5
`define BIT_STATE_B_WTM        7
`define BIT_ROUTE_SINGLE_KNOCK 0
`define BIT_ROUTE_DOUBLE_KNOCK 1
`define BIT_ROUTE_FREEFALL     2
`define BIT_ROUTE_WAKEUP       3
`define BIT_ROUTE_ORIENTATION  4
// ==========================================================
// queue mode codes
`define MODE_BYPASS            3'h0
`define MODE_STOP_FULL         3'h1
`define MODE_WTM_TO_FULL       3'h2
`define MODE_CONT_TO_STOP      3'h3
`define MODE_BYPASS_TO_CONT    3'h4
`define MODE_CONTINUOUS        3'h6
`define MODE_BYPASS_TO_STOP    3'h7
// ==========================================================
// reset values and sizes
`define RST_BYTE               8'h00
`define RST_MODE               3'h0
`define QUEUE_DEPTH            9'h100
`define EMPTY_TAG              8'hFF
`define WORD_W                 56
`endif

// ---- verilog/triggered_sample_queue_modes.v ----
// Notes on behaviour
// - bypass-to-continuous stores nothing until trigger
// - mode code 100 selects bypass-to-continuous
// - trigger is any routed detector event
// - trigger edge switches phase until bypass
// - continuous phase raises full flag early
// - mode code 111 selects bypass-to-stop
// - bypass-to-stop stores after trigger, stops full
// - wtm phase limits capacity, masks full
// - full phase removes limit, unmasks full
// - mode code 010 selects wtm-to-full
// - after trigger fill whole queue, then stop
// - output read returns oldest stored word
// - each tag read releases the oldest slot
// - nine-bit stored count across two registers
// - empty read returns empty-tagged word
// - burst address wraps last byte to tag
// - bypass clears queue and keeps empty
// - continuous overwrites oldest when full
// - threshold is eight-bit word count
// - halt bit limits capacity to threshold, except in wtm-to-full
//
// Added by the designer: the register offsets and strobed register access.
`include "sample_queue_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module triggered_sample_queue_modes (
  input  wire                clk,
  input  wire                nrst,
  input  wire [6:0]          addr,
  input  wire [7:0]          wdata,
  input  wire                wr_stb,
  input  wire                rd_stb,
  output reg  [7:0]          rdata_r,
  output reg  [6:0]          next_addr_r,
  input  wire                sample_clk,
  input  wire [`WORD_W-1:0]  sample_word,
  input  wire                ev_single_knock,
  input  wire                ev_double_knock,
  input  wire                ev_freefall,
  input  wire                ev_wakeup,
  input  wire                ev_orientation,
  output reg                 queue_full_flag_r,
  output reg                 post_trigger_r
);
  // ==========================================================
  // software registers
  reg  [7:0]          queue_threshold_level_r; // threshold in words
  reg                 halt_at_threshold_r;     // fixed capacity limit
  reg  [2:0]          mode_r;                  // queue mode field
  reg  [4:0]          irq_b_routing_r;         // event routing bits
  reg                 overrun_r;               // sticky overwrite flag
  // ==========================================================
  // queue storage
  reg  [`WORD_W-1:0]  mem [0:255];             // sample words
  reg  [7:0]          wr_ptr_r;                // next slot to fill
  reg  [7:0]          rd_ptr_r;                // oldest slot
  reg  [8:0]          count_r;                 // stored words
  reg  [`WORD_W-1:0]  out_buf_r;               // serial output buffer
  reg                 irq_b_prev_r;            // routed irq history
  // ==========================================================
  // derived control
  wire                sample_rise;             // new sample pulse
  wire                irq_b;                   // routed second irq
  wire                trig_edge;               // rising routed irq
  wire                is_bypass;               // queue disabled
  wire                pre_gate;                // nothing stored yet
  wire                stop_type;               // stop when full
  wire                wtm_limit;               // capacity limited
  wire                full_mask;               // full event masked
  wire [8:0]          cap;                     // current capacity
  wire                at_cap;                  // queue full now
  wire                pop;                     // tag read pops
  wire                push;                    // sample accepted
  wire                overwrite;               // drop oldest
  wire [8:0]          count_nxt;               // next count
  wire                stored_any;              // queue not empty

  edge_sync u_sample_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in (sample_clk),
    .rise_r   (sample_rise)
  );

  // routed events form the second interrupt line
  assign irq_b = |({ev_orientation, ev_wakeup, ev_freefall,
                    ev_double_knock, ev_single_knock} & irq_b_routing_r);
  // only a fresh edge counts, history refreshes even in bypass
  assign trig_edge = irq_b & ~irq_b_prev_r & ~is_bypass;

  assign is_bypass = (mode_r == `MODE_BYPASS);
  // bypass-first modes hold off storing until trigger
  assign pre_gate  = ~post_trigger_r &
                     ((mode_r == `MODE_BYPASS_TO_CONT) |
                      (mode_r == `MODE_BYPASS_TO_STOP));
  // which phases stop on full instead of overwriting
  assign stop_type = (mode_r == `MODE_STOP_FULL) |
                     (mode_r == `MODE_BYPASS_TO_STOP) |
                     (post_trigger_r & (mode_r == `MODE_CONT_TO_STOP)) |
                     (post_trigger_r & (mode_r == `MODE_WTM_TO_FULL));
  // wtm-to-full overrides halt bit in both phases
  assign wtm_limit = (mode_r == `MODE_WTM_TO_FULL) ? ~post_trigger_r
                                                   : halt_at_threshold_r;
  assign full_mask = (mode_r == `MODE_WTM_TO_FULL) & ~post_trigger_r;
  assign cap       = wtm_limit ? {1'b0, queue_threshold_level_r} : `QUEUE_DEPTH;
  assign at_cap    = (count_r >= cap);
  assign stored_any = (count_r != 9'h000);

  assign pop       = rd_stb & (addr == `ADDR_OUT_TAG) & ~is_bypass & stored_any;
  // a zero capacity stores nothing at all
  assign push      = sample_rise & ~is_bypass & ~pre_gate & (cap != 9'h000) &
                     ~(stop_type & at_cap & ~pop);
  assign overwrite = push & at_cap & ~pop & ~stop_type;
  assign count_nxt = (push & ~pop & ~overwrite) ? count_r + 9'h001 :
                     (pop & ~push)              ? count_r - 9'h001 : count_r;

  // ==========================================================
  // register writes and trigger phase
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      queue_threshold_level_r <= `RST_BYTE;
      halt_at_threshold_r     <= 1'b0;
      mode_r                  <= `RST_MODE;
      irq_b_routing_r         <= 5'h00;
      post_trigger_r          <= 1'b0;
      irq_b_prev_r            <= 1'b0;
    end
    else
    begin
      irq_b_prev_r <= irq_b;
      if (wr_stb)
      begin
        case (addr)
          `ADDR_QUEUE_CONTROL_A: queue_threshold_level_r <= wdata;
          `ADDR_QUEUE_CONTROL_B: halt_at_threshold_r <= wdata[`BIT_HALT_AT_THRESHOLD];
          `ADDR_QUEUE_CONTROL_D: mode_r <= wdata[2:0];
          `ADDR_IRQ_B_ROUTING:   irq_b_routing_r <= wdata[4:0];
          default:               mode_r <= mode_r; // unmapped writes ignored
        endcase
      end
      // phase drops in bypass so reselection starts over
      if (is_bypass)
        post_trigger_r <= 1'b0;
      else if (trig_edge)
        post_trigger_r <= 1'b1;
    end
  end

  // ==========================================================
  // storage array has no reset, only written by pushes
  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_r] <= sample_word;
  end

  // ==========================================================
  // pointers, count, overrun and full flag
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr_r          <= 8'h00;
      rd_ptr_r          <= 8'h00;
      count_r           <= 9'h000;
      overrun_r         <= 1'b0;
      queue_full_flag_r <= 1'b0;
    end
    else if (is_bypass)
    begin
      // whole content dropped while bypass stands
      wr_ptr_r          <= 8'h00;
      rd_ptr_r          <= 8'h00;
      count_r           <= 9'h000;
      overrun_r         <= 1'b0;
      queue_full_flag_r <= 1'b0;
    end
    else
    begin
      // with a limited capacity the ring still spans all slots
      if (push)
        wr_ptr_r <= wr_ptr_r + 8'h01;
      if (pop | overwrite)
        rd_ptr_r <= rd_ptr_r + 8'h01;
      count_r <= count_nxt;
      // sticky; a new overwrite beats the clearing read
      if (overwrite)
        overrun_r <= 1'b1;
      else if (rd_stb & (addr == `ADDR_QUEUE_STATE_B))
        overrun_r <= 1'b0;
      // warns one write ahead: next push fills or overruns
      queue_full_flag_r <= ~full_mask & (cap != 9'h000) &
                           (count_nxt + 9'h001 >= cap);
    end
  end

  // ==========================================================
  // read data, output buffer and burst address
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_r     <= `RST_BYTE;
      out_buf_r   <= {`WORD_W{1'b0}};
      next_addr_r <= `ADDR_OUT_TAG;
    end
    else
    begin
      if (rd_stb)
      begin
        // burst pointer for the serial front end
        if (addr == `ADDR_OUT_BYTE_5)
          next_addr_r <= `ADDR_OUT_TAG;
        else
          next_addr_r <= addr + 7'h01;
        case (addr)
          `ADDR_OUT_TAG:
          begin
            // word moves into the output buffer on the tag read
            if (pop)
            begin
              out_buf_r <= mem[rd_ptr_r];
              rdata_r   <= mem[rd_ptr_r][`WORD_W-1:`WORD_W-8];
            end
            else
            begin
              out_buf_r <= {`EMPTY_TAG, 48'h0};
              rdata_r   <= `EMPTY_TAG;
            end
          end
          7'h79:                  rdata_r <= out_buf_r[7:0];
          7'h7A:                  rdata_r <= out_buf_r[15:8];
          7'h7B:                  rdata_r <= out_buf_r[23:16];
          7'h7C:                  rdata_r <= out_buf_r[31:24];
          7'h7D:                  rdata_r <= out_buf_r[39:32];
          `ADDR_OUT_BYTE_5:       rdata_r <= out_buf_r[47:40];
          `ADDR_QUEUE_CONTROL_A:  rdata_r <= queue_threshold_level_r;
          `ADDR_QUEUE_CONTROL_B:  rdata_r <= {7'h00, halt_at_threshold_r};
          `ADDR_QUEUE_CONTROL_D:  rdata_r <= {5'h00, mode_r};
          `ADDR_IRQ_B_ROUTING:    rdata_r <= {3'h0, irq_b_routing_r};
          `ADDR_QUEUE_STATE_A:    rdata_r <= count_r[7:0];
          `ADDR_QUEUE_STATE_B:    rdata_r <= {(count_r >= {1'b0, queue_threshold_level_r}),
                                              overrun_r, queue_full_flag_r,
                                              4'h0, count_r[8]};
          default:                rdata_r <= 8'h00;  // unmapped reads zero
        endcase
      end
      else
        rdata_r <= 8'h00;
    end
  end
endmodule // triggered_sample_queue_modes
`default_nettype wire
